// *** include/ssp_defs.svh ***
// What this block does
// - an eight-bit shift register and a four-bit pulse counter are both stepped by the serial clock pin.
// - bits enter from the serial input pin and the shifted data leaves on the serial output pin.
// - each byte goes out and comes in with its most significant bit first.
// - each falling edge of the serial clock, up to the eighth, advances the shift register and the counter together.
// - after eight falling edges the counter terminal output goes low and stops all further shifting until re-armed.
// - an interrupt request is raised on the eighth falling edge while the interrupt is enabled, unless a data write has reset the counter first.
// - the interrupt is disabled after reset.
// - a data write enables the end-of-byte interrupt and a write with byte lane 0 to the disable register disables it.
// - the interrupt request is a high-to-low transition on its output.
// - reset or a data write clears the counter and re-enables shifting, with no start condition needed.
// - with the output pin in open-drain mode it carries the shift register output, otherwise it is plain I/O.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// register indices; byte address is four times the index
`define SSP_IDX_DISABLE 8'hdc
`define SSP_IDX_DATA 8'hdd
`define SSP_IDX_CTRL 8'hde
`define SSP_IDX_STATUS 8'hdf

// control register fields
`define SSP_CTRL_OPEN_DRAIN 0
`define SSP_CTRL_PORT_BIT 1

// status register fields
`define SSP_STAT_TERMINAL 0
`define SSP_STAT_COUNT_LO 1
`define SSP_STAT_COUNT_HI 4
`define SSP_STAT_IRQ_EN 5
`define SSP_STAT_IRQ_PEND 6

// counter values
`define SSP_COUNT_ZERO 4'h0
`define SSP_COUNT_ONE 4'h1
`define SSP_COUNT_LAST 4'h7
`define SSP_COUNT_DONE 4'h8
`define SSP_BYTE_ZERO 8'h00
`define SSP_WORD_ZERO 32'h0000_0000

`endif

// *** include/ssp_pkg.sv ***
package ssp_pkg;

   // answers of the register bus
   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } axi_resp_e;

   typedef logic [7:0] reg_index_t;

endpackage

// *** design/simple_serial_shift_port.sv ***
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defs.svh"

module simple_serial_shift_port #(
   parameter int ADDR_WIDTH = 12
) (
   // system clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // axi4-lite write address
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output ssp_pkg::axi_resp_e s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output ssp_pkg::axi_resp_e s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // serial link pins
   input wire logic serial_clk,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_n,
   // end-of-byte request, falling edge active
   output logic serial_irq_n
);
   import ssp_pkg::*;

   // ************************************************************
   // link clock domain
   // ************************************************************

   // the link clock may stand still, so these two flops get a
   // power-up value instead of a reset that would need an edge
   logic link_bit = 1'b0;
   logic link_toggle = 1'b0;

   always_ff @(negedge serial_clk) begin
      link_bit <= serial_in;
      link_toggle <= ~link_toggle;
   end

   // ************************************************************
   // crossing into the system domain
   // ************************************************************

   // power-up values here too, so no unknown reaches the edge
   // detector before the first link edge arrives
   logic tog_meta = 1'b0;
   logic tog_sync = 1'b0;
   logic tog_seen = 1'b0;
   logic tog_prev = 1'b0;
   logic bit_meta = 1'b0;
   logic bit_sync = 1'b0;
   logic fall_event;

   // two flops for the edge toggle and two for the captured bit;
   // the bit stands still for a whole link period after its edge
   always_ff @(posedge sys_clk) begin
      tog_meta <= link_toggle;
      tog_sync <= tog_meta;
      bit_meta <= link_bit;
      bit_sync <= bit_meta;
   end

   // the edge is detected one stage behind the synchronised toggle:
   // the toggle chain is one flop deeper than the bit chain, so a bit flop that resolved late
   // gets a second sample before the shifter reads it
   always_ff @(posedge sys_clk) begin
      tog_seen <= tog_sync;
      tog_prev <= tog_seen;
   end

   // one pulse per falling edge of the serial clock; a link edge
   // reaches the shifter three to four system clocks after it falls;
   // link edges less than one system clock apart could be lost
   assign fall_event = tog_seen ^ tog_prev;

   // ************************************************************
   // register bus: write channels
   // ************************************************************

   logic aw_held;
   logic w_held;
   logic [ADDR_WIDTH-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic hit_disable;
   logic hit_data;
   logic hit_ctrl;
   logic hit_status;
   logic write_mapped;
   logic data_write;
   logic disable_write;
   logic ctrl_write;

   // address and data may arrive in either order; each is held
   // until both are present and the response has been taken
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // write data channel, mirror of the address side
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         w_held <= 1'b0;
         w_data <= `SSP_WORD_ZERO;
         w_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // word address decode; upper address bits must be zero
   assign hit_disable = (aw_addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(`SSP_IDX_DISABLE));
   assign hit_data = (aw_addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(`SSP_IDX_DATA));
   assign hit_ctrl = (aw_addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(`SSP_IDX_CTRL));
   assign hit_status = (aw_addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(`SSP_IDX_STATUS));
   assign write_mapped = hit_disable || hit_data || hit_ctrl || hit_status;

   // only byte lane 0 carries register data; a write without it
   // is answered but has no effect
   assign data_write = do_write && hit_data && w_strb[0];
   assign disable_write = do_write && hit_disable && w_strb[0];
   assign ctrl_write = do_write && hit_ctrl && w_strb[0];

   // write response; unmapped addresses get slverr
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= write_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // shift register and pulse counter
   // ************************************************************

   logic [7:0] shift_data;
   logic [3:0] pulse_count;
   logic counter_terminal_output;
   logic shift_step;

   // terminal output is high while fewer than eight edges are in
   // terminal output low
   assign counter_terminal_output = (pulse_count != `SSP_COUNT_DONE);
   assign shift_step = fall_event && counter_terminal_output;

   // a data write wins over a falling edge in the same cycle
   // clear and re-arm
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pulse_count <= `SSP_COUNT_ZERO;
      end else if (data_write) begin
         pulse_count <= `SSP_COUNT_ZERO;
      end else if (shift_step) begin
         pulse_count <= pulse_count + `SSP_COUNT_ONE;
      end
   end

   // msb leaves first, new bit enters at the lsb
   // byte shift register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         shift_data <= `SSP_BYTE_ZERO;
      end else if (data_write) begin
         shift_data <= w_data[7:0];
      end else if (shift_step) begin
         shift_data <= {shift_data[6:0], bit_sync};
      end
   end

   // ************************************************************
   // end-of-byte interrupt request
   // ************************************************************

   logic irq_enable;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_enable <= 1'b0;
      end else if (data_write) begin
         irq_enable <= 1'b1;
      end else if (disable_write) begin
         irq_enable <= 1'b0;
      end
   end

   // the request falls on the eighth edge and stays low until the
   // port is re-armed or disabled, so an edge-sensitive core input
   // sees exactly one transition per byte
   // high to low request
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         serial_irq_n <= 1'b1;
      end else if (data_write) begin
         serial_irq_n <= 1'b1;
      end else if (shift_step && irq_enable && pulse_count == `SSP_COUNT_LAST) begin
         serial_irq_n <= 1'b0;
      // an eighth edge landing with a disable write still wins
      end else if (disable_write) begin
         serial_irq_n <= 1'b1;
      end
   end

   // ************************************************************
   // output pin
   // ************************************************************

   logic open_drain;
   logic port_bit;

   // pin mode and plain port level
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         open_drain <= 1'b0;
         port_bit <= 1'b1;
      end else if (ctrl_write) begin
         open_drain <= w_data[`SSP_CTRL_OPEN_DRAIN];
         port_bit <= w_data[`SSP_CTRL_PORT_BIT];
      end
   end

   // open drain pulls low for a zero and releases for a one, so the
   // line can be shared with other open-drain parties
   // open-drain routes shifter
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         serial_out <= 1'b1;
         serial_out_oe_n <= 1'b1;
      end else if (open_drain) begin
         serial_out <= 1'b0;
         serial_out_oe_n <= shift_data[7];
      end else begin
         serial_out <= port_bit;
         serial_out_oe_n <= 1'b0;
      end
   end

   // ************************************************************
   // register bus: read channel
   // ************************************************************

   logic [31:0] next_rdata;
   logic read_mapped;
   logic [ADDR_WIDTH-3:0] rd_index;

   assign rd_index = s_axi_araddr[ADDR_WIDTH-1:2];

   // reads have no side effects on any state
   // read without effect
   always_comb begin
      next_rdata = `SSP_WORD_ZERO;
      read_mapped = 1'b1;
      if (rd_index == (ADDR_WIDTH-2)'(`SSP_IDX_DATA)) begin
         next_rdata[7:0] = shift_data;
      end else if (rd_index == (ADDR_WIDTH-2)'(`SSP_IDX_CTRL)) begin
         next_rdata[`SSP_CTRL_OPEN_DRAIN] = open_drain;
         next_rdata[`SSP_CTRL_PORT_BIT] = port_bit;
      end else if (rd_index == (ADDR_WIDTH-2)'(`SSP_IDX_STATUS)) begin
         next_rdata[`SSP_STAT_TERMINAL] = counter_terminal_output;
         next_rdata[`SSP_STAT_COUNT_HI:`SSP_STAT_COUNT_LO] = pulse_count;
         next_rdata[`SSP_STAT_IRQ_EN] = irq_enable;
         next_rdata[`SSP_STAT_IRQ_PEND] = ~serial_irq_n;
      end else if (rd_index != (ADDR_WIDTH-2)'(`SSP_IDX_DISABLE)) begin
         read_mapped = 1'b0;
      end
   end

   // one read at a time; data is answered the cycle after the
   // address is taken and held until rready
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `SSP_WORD_ZERO;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= read_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// *** bench/ssp_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defs.svh"
module ssp_props import ssp_pkg::*; #(
   parameter int ADDR_WIDTH = 12
) (
   // clock, reset
   input wire logic sys_clk,
   input wire logic reset,
   // register bus
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire axi_resp_e s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link pins
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic serial_irq_n
);
   // ****************
   // bus and link checks
   // ****************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_irq_reset: assert property (disable iff (1'b0) reset |=> serial_irq_n)
      else $error("request not idle after reset");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
      else $error("second write taken");
   // a disable write lets the request line go within a few cycles
   a_irq_release: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
      && s_axi_awaddr == ADDR_WIDTH'(`SSP_IDX_DISABLE * 4) |-> ##[1:4] serial_irq_n)
      else $error("request kept after disable");
   a_irq_cause: assert property ($rose(serial_irq_n) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("request released without a write");
   // past reset guards the reset value of the pins at the first edge
   a_pin_drain: assert property (serial_out_oe_n && !$past(reset) |-> !serial_out)
      else $error("released pin with data high");
endmodule
bind simple_serial_shift_port ssp_props #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.sys_clk(sys_clk), .reset(reset),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_out(serial_out),
   .serial_out_oe_n(serial_out_oe_n), .serial_irq_n(serial_irq_n));
`default_nettype wire

// *** bench/serial_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_master_model (
   // link pins
   output logic serial_clk,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   // ****************
   // far side master
   // ****************
   // clock idles high between frames, like a pulled-up line
   initial begin
      serial_clk = 1'b1;
      serial_in = 1'b1;
   end
   task automatic send_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serial_in = tx[i];
         #31.2;
         // released pin reads the pull-up level
         rx[i] = serial_out_oe_n ? 1'b1 : serial_out;
         serial_clk = 1'b0;
         #62.5;
         // last low phase held longer, as a stretching slave would
         if (i == 0) #250.0;
         serial_clk = 1'b1;
         #31.3;
      end
      serial_in = ~tx[0]; // stale data must not look valid
   endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defs.svh"
module testbench;
   import ssp_pkg::*;
   localparam logic [11:0] A_DIS = 12'(`SSP_IDX_DISABLE * 4);
   localparam logic [11:0] A_DAT = 12'(`SSP_IDX_DATA * 4);
   localparam logic [11:0] A_CTL = 12'(`SSP_IDX_CTRL * 4);
   localparam logic [11:0] A_STA = 12'(`SSP_IDX_STATUS * 4);
   logic sys_clk, reset, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic serial_clk, serial_in, serial_out, serial_out_oe_n, serial_irq_n;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [7:0] rx;
   axi_resp_e bresp, rresp, resp;
   int mismatches, tests_run;
   simple_serial_shift_port dut_u (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .serial_irq_n(serial_irq_n));
   serial_master_model pt_u (.serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n));
   // ****************
   // clock, tasks
   // ****************
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ready may be raised before valid is seen, so each valid stays up until its ready
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output axi_resp_e r);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge sys_clk);
         if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
         if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
      end
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      bready <= 1'b1;
      @(posedge sys_clk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output axi_resp_e r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rready <= 1'b1;
      @(posedge sys_clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic do_reset;
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
   endtask
   initial begin
      #40000;
      $display("[ERR] %0t watchdog expired", $time);
      mismatches++;
      report_and_stop;
   end
   // ****************
   // test sequence
   // ****************
   initial begin
      {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h01 << 5;
      {awaddr, araddr, wdata} = 56'h0;
      mismatches = 0;
      tests_run = 0;
      @(posedge sys_clk);
      do_reset;
      rd_reg(A_STA, rd, resp); chk(rd, 32'h0000_0001);
      rd_reg(A_CTL, rd, resp); chk(rd, 32'h0000_0002);
      rd_reg(A_DAT, rd, resp); chk(rd, 32'h0000_0000);
      $display("test reset values done");
      wr(12'h000, 32'h0000_0001, resp); chk(32'(resp), 32'(RESP_SLVERR));
      rd_reg(12'h004, rd, resp); chk(32'(resp), 32'(RESP_SLVERR));
      $display("test unmapped done");
      wr(A_CTL, 32'h0000_0001, resp);
      wr(A_DAT, 32'h0000_00a5, resp);
      rd_reg(A_STA, rd, resp); chk(rd, 32'h0000_0021);
      pt_u.send_byte(8'h3c, rx); chk(32'(rx), 32'h0000_00a5);
      repeat (4) @(posedge sys_clk);
      chk(32'(serial_irq_n), 32'h0000_0000);
      rd_reg(A_DAT, rd, resp); chk(rd, 32'h0000_003c);
      rd_reg(A_STA, rd, resp); chk(rd, 32'h0000_0070);
      $display("test byte exchange done");
      pt_u.send_byte(8'hff, rx);
      repeat (6) @(posedge sys_clk);
      rd_reg(A_DAT, rd, resp); chk(rd, 32'h0000_003c);
      wr(A_DIS, 32'h0000_0000, resp); chk(32'(serial_irq_n), 32'h0000_0001);
      rd_reg(A_STA, rd, resp); chk(rd, 32'h0000_0010);
      $display("test freeze and disable done");
      wr(A_DAT, 32'h0000_0000, resp);
      wr(A_DIS, 32'h0000_00ff, resp);
      pt_u.send_byte(8'h99, rx);
      repeat (6) @(posedge sys_clk);
      chk(32'(serial_irq_n), 32'h0000_0001);
      rd_reg(A_DAT, rd, resp); chk(rd, 32'h0000_0099);
      $display("test masked byte done");
      wr(A_CTL, 32'h0000_0000, resp);
      repeat (3) @(posedge sys_clk);
      chk({30'h0, serial_out, serial_out_oe_n}, 32'h0000_0000);
      do_reset;
      rd_reg(A_STA, rd, resp); chk(rd, 32'h0000_0001);
      chk({30'h0, serial_out, serial_out_oe_n}, 32'h0000_0002);
      $display("test plain pin and reset done");
      report_and_stop;
   end
endmodule
`default_nettype wire
